/* rtl/fmr_defines.svh */
// register addresses, reset values, field positions and timing constants for the fan monitor
`ifndef FMR_DEFINES_SVH
`define FMR_DEFINES_SVH

// register addresses
`define FMR_ADDR_EXT3_HIGH    8'h32
`define FMR_ADDR_INT_HIGH     8'h34
`define FMR_ADDR_FAN_DRIVE    8'h40
`define FMR_ADDR_FAN_CFG1     8'h42
`define FMR_ADDR_FAN_CFG2     8'h43
`define FMR_ADDR_GAIN         8'h45
`define FMR_ADDR_SPIN_UP      8'h46
`define FMR_ADDR_STEP         8'h47
`define FMR_ADDR_MIN_DRIVE    8'h48
`define FMR_ADDR_VALID_TACH   8'h49
`define FMR_ADDR_BAND_LOW     8'h4a
`define FMR_ADDR_BAND_HIGH    8'h4b
`define FMR_ADDR_TARGET_LOW   8'h4c
`define FMR_ADDR_TARGET_HIGH  8'h4d
`define FMR_ADDR_TACH_HIGH    8'h4e
`define FMR_ADDR_TACH_LOW     8'h4f
`define FMR_ADDR_LOCK         8'hef
`define FMR_ADDR_FEATURES     8'hfc
`define FMR_ADDR_PART_ID      8'hfd
`define FMR_ADDR_MAKER_ID     8'hfe
`define FMR_ADDR_REVISION     8'hff

// reset values
`define FMR_RST_HIGH_LIMIT    8'h55
`define FMR_RST_FAN_DRIVE     8'h00
`define FMR_RST_FAN_CFG1      8'h2b
`define FMR_RST_FAN_CFG2      8'h28
`define FMR_RST_GAIN          8'h2a
`define FMR_RST_SPIN_UP       8'h00
`define FMR_RST_STEP          8'h10
`define FMR_RST_MIN_DRIVE     8'h66
`define FMR_RST_VALID_TACH    8'hf5
`define FMR_RST_BAND          8'h00
`define FMR_RST_TARGET_LOW    8'hf8
`define FMR_RST_TARGET_HIGH   8'hff
`define FMR_RST_TACH_HIGH     8'hff
`define FMR_RST_TACH_LOW      8'hff
`define FMR_RST_LOCK          8'h00
`define FMR_RST_FEATURES      8'h00
`define FMR_UNMAPPED_DATA     8'h00

// field positions and special values
`define FMR_LOCK_BIT          0
`define FMR_CFG1_EN_BIT       7
`define FMR_BYTE_MSB          7
`define FMR_BIT_LAST          3'h7
`define FMR_DRIVE_FULL        8'hff
`define FMR_DRIVE_OFF         8'h00
`define FMR_TARGET_OFF        16'hffff

// timing: loop update period and clock rate
`define FMR_UPDATE_US         1000
`define FMR_CLK_MHZ           25

`endif

/* rtl/fmr_pkg.sv */
// shared types of the fan monitor register block
package fmr_pkg;
  // one register byte
  typedef logic [7:0] fmr_byte_t;
  // serial slave protocol states
  typedef enum logic [3:0] {
    FMR_IDLE  = 4'b0000,
    FMR_ADDR  = 4'b0001,
    FMR_AACK  = 4'b0010,
    FMR_CMD   = 4'b0011,
    FMR_CACK  = 4'b0100,
    FMR_WDATA = 4'b0101,
    FMR_WACK  = 4'b0110,
    FMR_RDATA = 4'b0111,
    FMR_MACK  = 4'b1000,
    FMR_RLOAD = 4'b1001
  } fmr_state_e;
endpackage

/* rtl/fmr_reg_if.sv */
// carrier between the serial front end and the register bank
`timescale 1ns/1ns
interface fmr_reg_if;
  logic [7:0] addr;        // register pointer
  logic [7:0] wdata;       // write byte
  logic wr_stb;            // one-cycle write strobe
  logic [7:0] rdata;       // read byte at addr
  logic [7:0] cfg1;        // loop configuration
  logic [7:0] step;        // largest drive change per update when target is on and drive is not below the floor
  logic [7:0] min_drive;   // drive floor while running
  logic [7:0] valid_tach;  // stall threshold on the high count byte
  logic [15:0] fail_band;  // tolerance at full drive
  logic [15:0] target;     // tachometer target
  logic [15:0] tach;       // measured count
  logic [7:0] strap;       // synchronised strap pins
  logic [7:0] drive;       // current fan drive
  logic [7:0] loop_drive;  // drive computed by the loop
  logic loop_upd;          // loop drive valid strobe
  modport front (output addr, output wdata, output wr_stb, input rdata, input cfg1,
                 input step, input min_drive, input valid_tach, input fail_band,
                 input target, output tach, output strap, input drive,
                 output loop_drive, output loop_upd);
  modport bank (input addr, input wdata, input wr_stb, output rdata, output cfg1,
                output step, output min_drive, output valid_tach, output fail_band,
                output target, input tach, input strap, output drive,
                input loop_drive, input loop_upd);
endinterface // fmr_reg_if

/* rtl/fmr_regbank.sv */
// register bank with lock protection and read multiplexer
`timescale 1ns/1ns
`include "fmr_defines.svh"
module fmr_regbank #(
  parameter logic [7:0] PART_ID = 8'h7a,   // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h4e,  // arbitrary value
  parameter logic [7:0] REVISION = 8'h03   // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  fmr_reg_if.bank rb
);
  fmr_pkg::fmr_byte_t ext3_high_ff, int_high_ff, drive_ff, cfg1_ff, cfg2_ff, gain_ff;
  fmr_pkg::fmr_byte_t spin_ff, step_ff, min_ff, valid_ff, band_lo_ff, band_hi_ff;
  fmr_pkg::fmr_byte_t tgt_lo_ff, tgt_hi_ff, tach_hi_ff, tach_lo_ff, lock_ff, feat_ff;
  logic locked;         // lockable class is read only
  logic wr;             // host write strobe

  assign locked = lock_ff[`FMR_LOCK_BIT];
  assign wr = rb.wr_stb;

  // host writes; defaults loaded by reset
  always_ff @(posedge clk) begin
    if (reset) begin
      ext3_high_ff <= `FMR_RST_HIGH_LIMIT;
      int_high_ff <= `FMR_RST_HIGH_LIMIT;
      cfg1_ff <= `FMR_RST_FAN_CFG1;
      cfg2_ff <= `FMR_RST_FAN_CFG2;
      gain_ff <= `FMR_RST_GAIN;
      spin_ff <= `FMR_RST_SPIN_UP;
      step_ff <= `FMR_RST_STEP;
      min_ff <= `FMR_RST_MIN_DRIVE;
      valid_ff <= `FMR_RST_VALID_TACH;
      band_lo_ff <= `FMR_RST_BAND;
      band_hi_ff <= `FMR_RST_BAND;
      tgt_lo_ff <= `FMR_RST_TARGET_LOW;
      tgt_hi_ff <= `FMR_RST_TARGET_HIGH;
      lock_ff <= `FMR_RST_LOCK;
    end else if (wr) begin
      case (rb.addr)
        `FMR_ADDR_FAN_CFG1: cfg1_ff <= rb.wdata;
        `FMR_ADDR_TARGET_LOW: tgt_lo_ff <= rb.wdata;
        `FMR_ADDR_TARGET_HIGH: tgt_hi_ff <= rb.wdata;
        default: begin
          if (!locked) begin
            case (rb.addr)
              `FMR_ADDR_EXT3_HIGH: ext3_high_ff <= rb.wdata;
              `FMR_ADDR_INT_HIGH: int_high_ff <= rb.wdata;
              `FMR_ADDR_FAN_CFG2: cfg2_ff <= rb.wdata;
              `FMR_ADDR_GAIN: gain_ff <= rb.wdata;
              `FMR_ADDR_SPIN_UP: spin_ff <= rb.wdata;
              `FMR_ADDR_STEP: step_ff <= rb.wdata;
              `FMR_ADDR_MIN_DRIVE: min_ff <= rb.wdata;
              `FMR_ADDR_VALID_TACH: valid_ff <= rb.wdata;
              `FMR_ADDR_BAND_LOW: band_lo_ff <= rb.wdata;
              `FMR_ADDR_BAND_HIGH: band_hi_ff <= rb.wdata;
              // lock register locks itself, so it sticks
              `FMR_ADDR_LOCK: lock_ff <= rb.wdata;
              default: lock_ff <= lock_ff;
            endcase
          end
        end
      endcase
    end
  end

  // fan drive: loop owns it when enabled, host otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      drive_ff <= `FMR_RST_FAN_DRIVE;
    end else if (cfg1_ff[`FMR_CFG1_EN_BIT]) begin
      if (rb.loop_upd) begin
        drive_ff <= rb.loop_drive;
      end
    end else if (wr && rb.addr == `FMR_ADDR_FAN_DRIVE) begin
      // direct control when loop is off
      drive_ff <= rb.wdata;
    end
  end

  // live tachometer count and strap report
  always_ff @(posedge clk) begin
    if (reset) begin
      tach_hi_ff <= `FMR_RST_TACH_HIGH;
      tach_lo_ff <= `FMR_RST_TACH_LOW;
      feat_ff <= `FMR_RST_FEATURES;
    end else begin
      // count is only ever loaded from hardware
      tach_hi_ff <= rb.tach[15:8];
      tach_lo_ff <= rb.tach[7:0];
      // follows the synchronised straps
      // a one-shot capture would only ever see the synchroniser's reset value
      feat_ff <= rb.strap;
    end
  end

  // read multiplexer
  always_comb begin
    case (rb.addr)
      `FMR_ADDR_EXT3_HIGH: rb.rdata = ext3_high_ff;
      `FMR_ADDR_INT_HIGH: rb.rdata = int_high_ff;
      `FMR_ADDR_FAN_DRIVE: rb.rdata = drive_ff;
      `FMR_ADDR_FAN_CFG1: rb.rdata = cfg1_ff;
      `FMR_ADDR_FAN_CFG2: rb.rdata = cfg2_ff;
      `FMR_ADDR_GAIN: rb.rdata = gain_ff;
      `FMR_ADDR_SPIN_UP: rb.rdata = spin_ff;
      `FMR_ADDR_STEP: rb.rdata = step_ff;
      `FMR_ADDR_MIN_DRIVE: rb.rdata = min_ff;
      `FMR_ADDR_VALID_TACH: rb.rdata = valid_ff;
      `FMR_ADDR_BAND_LOW: rb.rdata = band_lo_ff;
      `FMR_ADDR_BAND_HIGH: rb.rdata = band_hi_ff;
      `FMR_ADDR_TARGET_LOW: rb.rdata = tgt_lo_ff;
      `FMR_ADDR_TARGET_HIGH: rb.rdata = tgt_hi_ff;
      `FMR_ADDR_TACH_HIGH: rb.rdata = tach_hi_ff;
      `FMR_ADDR_TACH_LOW: rb.rdata = tach_lo_ff;
      `FMR_ADDR_LOCK: rb.rdata = lock_ff;
      `FMR_ADDR_FEATURES: rb.rdata = feat_ff;
      `FMR_ADDR_PART_ID: rb.rdata = PART_ID;
      `FMR_ADDR_MAKER_ID: rb.rdata = MAKER_ID;
      `FMR_ADDR_REVISION: rb.rdata = REVISION;
      default: rb.rdata = `FMR_UNMAPPED_DATA;
    endcase
  end

  assign rb.cfg1 = cfg1_ff;
  assign rb.step = step_ff;
  assign rb.min_drive = min_ff;
  assign rb.valid_tach = valid_ff;
  assign rb.fail_band = {band_hi_ff, band_lo_ff};
  assign rb.target = {tgt_hi_ff, tgt_lo_ff};
  assign rb.drive = drive_ff;
endmodule // fmr_regbank

/* rtl/fmr_top.sv */
// serial register slave and closed-loop fan drive of the fan monitor
`timescale 1ns/1ns
`include "fmr_defines.svh"

module fmr_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2c,  // serial slave address
  parameter int UPDATE_CYCLES = `FMR_UPDATE_US * `FMR_CLK_MHZ  // loop update period
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [15:0] TACH_COUNT,
  input wire logic [7:0] STRAP_PINS,
  output logic [7:0] FAN_DRIVE,
  output logic FAN_STALL,
  output logic FAN_DRIVE_FAIL
);
  // carrier to the register bank
  fmr_reg_if rif ();

  // pin synchronisers, two stages each
  logic scl_s1_ff, scl_s2_ff;        // clock pin stages
  logic sda_s1_ff, sda_s2_ff;        // data pin stages
  logic [7:0] strap_s1_ff, strap_s2_ff;  // strap pin stages
  logic scl_d_ff, sda_d_ff;          // delayed copies for edge detection

  // edge and condition detects, all from the second stage onward
  logic scl_rise, scl_fall;
  logic start_det, stop_det;

  // protocol state
  fmr_pkg::fmr_state_e st_ff;        // slave state
  logic [2:0] cnt_ff;                // bit count inside a byte
  logic [7:0] sh_ff;                 // shift register
  logic done_ff;                     // eight bits received
  logic rw_ff;                       // direction bit of the address byte
  logic ack_ff;                      // host acknowledged last read byte
  logic [7:0] ptr_ff;                // register pointer
  logic [7:0] wdata_ff;              // byte handed to the bank
  logic wr_ff;                       // write strobe to the bank
  logic oe_ff;                       // pulling the data line low

  // loop state
  logic [19:0] tick_cnt_ff;          // update divider
  logic tick_ff;                     // one-cycle update enable
  logic [7:0] loop_drive_ff;         // computed drive
  logic loop_upd_ff;                 // computed drive strobe
  logic stall_ff;                    // fan below valid count
  logic fail_ff;                     // target missed at full drive
  logic [15:0] tach_ff;              // sampled count

  // loop arithmetic
  logic [7:0] head_room;             // distance to full drive
  logic [7:0] up_step;               // allowed rise
  logic [7:0] down_step;             // allowed fall
  logic [7:0] raw_drive;             // drive before the floor
  logic [7:0] nxt_drive;             // drive after the floor
  logic [16:0] fail_limit;           // target plus band, one bit wider

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      strap_s1_ff <= 8'h00;
      strap_s2_ff <= 8'h00;
    end else begin
      scl_s1_ff <= SCL_IN;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= SDA_IN;
      sda_s2_ff <= sda_s1_ff;
      strap_s1_ff <= STRAP_PINS;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // delayed copies of the synchronised lines
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s2_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  // line events; start and stop only count while the clock line is high
  assign scl_rise = scl_s2_ff && !scl_d_ff;
  assign scl_fall = !scl_s2_ff && scl_d_ff;
  assign start_det = scl_s2_ff && scl_d_ff && !sda_s2_ff && sda_d_ff;
  assign stop_det = scl_s2_ff && scl_d_ff && sda_s2_ff && !sda_d_ff;

  // serial slave protocol
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_ff <= fmr_pkg::FMR_IDLE;
      cnt_ff <= 3'h0;
      sh_ff <= 8'h00;
      done_ff <= 1'b0;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      ptr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      if (stop_det) begin
        // stop releases the line whatever the state
        st_ff <= fmr_pkg::FMR_IDLE;
        oe_ff <= 1'b0;
      end else if (start_det) begin
        // start or repeated start; pointer survives for reads
        st_ff <= fmr_pkg::FMR_ADDR;
        cnt_ff <= 3'h0;
        done_ff <= 1'b0;
        oe_ff <= 1'b0;
      end else begin
        case (st_ff)
          // receiving states share the shifter
          fmr_pkg::FMR_ADDR, fmr_pkg::FMR_CMD, fmr_pkg::FMR_WDATA: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda_s2_ff};
              cnt_ff <= cnt_ff + 3'h1;
              done_ff <= (cnt_ff == `FMR_BIT_LAST);
            end else if (scl_fall && done_ff) begin
              done_ff <= 1'b0;
              if (st_ff == fmr_pkg::FMR_ADDR) begin
                // answer only our own address
                if (sh_ff[7:1] == SLAVE_ADDR) begin
                  rw_ff <= sh_ff[0];
                  oe_ff <= 1'b1;
                  st_ff <= fmr_pkg::FMR_AACK;
                end else begin
                  st_ff <= fmr_pkg::FMR_IDLE;
                end
              end else if (st_ff == fmr_pkg::FMR_CMD) begin
                // command byte sets the pointer
                ptr_ff <= sh_ff;
                oe_ff <= 1'b1;
                st_ff <= fmr_pkg::FMR_CACK;
              end else begin
                // data byte goes to the bank as a one-cycle strobe
                wdata_ff <= sh_ff;
                wr_ff <= 1'b1;
                oe_ff <= 1'b1;
                st_ff <= fmr_pkg::FMR_WACK;
              end
            end
          end
          // address acknowledged; read starts driving bit seven here
          fmr_pkg::FMR_AACK: begin
            if (scl_fall) begin
              cnt_ff <= 3'h0;
              if (rw_ff) begin
                sh_ff <= rif.rdata;
                oe_ff <= !rif.rdata[`FMR_BYTE_MSB];
                st_ff <= fmr_pkg::FMR_RDATA;
              end else begin
                oe_ff <= 1'b0;
                st_ff <= fmr_pkg::FMR_CMD;
              end
            end
          end
          // command acknowledged
          fmr_pkg::FMR_CACK: begin
            if (scl_fall) begin
              oe_ff <= 1'b0;
              cnt_ff <= 3'h0;
              st_ff <= fmr_pkg::FMR_WDATA;
            end
          end
          // data acknowledged; block writes step the pointer
          fmr_pkg::FMR_WACK: begin
            if (scl_fall) begin
              oe_ff <= 1'b0;
              cnt_ff <= 3'h0;
              ptr_ff <= ptr_ff + 8'h01;
              st_ff <= fmr_pkg::FMR_WDATA;
            end
          end
          // shift a read byte out, msb first
          fmr_pkg::FMR_RDATA: begin
            if (scl_fall) begin
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == `FMR_BIT_LAST) begin
                oe_ff <= 1'b0;
                st_ff <= fmr_pkg::FMR_MACK;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                oe_ff <= !sh_ff[6];
              end
            end
          end
          // host ack bit; a nack ends the read
          fmr_pkg::FMR_MACK: begin
            if (scl_rise) begin
              ack_ff <= !sda_s2_ff;
              if (!sda_s2_ff) begin
                ptr_ff <= ptr_ff + 8'h01;
                st_ff <= fmr_pkg::FMR_RLOAD;
              end else begin
                st_ff <= fmr_pkg::FMR_IDLE;
              end
            end
          end
          // next byte is fetched on the clock fall that ends the host ack bit
          fmr_pkg::FMR_RLOAD: begin
            if (scl_fall) begin
              sh_ff <= rif.rdata;
              oe_ff <= !rif.rdata[`FMR_BYTE_MSB];
              cnt_ff <= 3'h0;
              st_ff <= fmr_pkg::FMR_RDATA;
            end
          end
          // idle waits for a start
          fmr_pkg::FMR_IDLE: begin
            oe_ff <= 1'b0;
          end
          default: begin
            st_ff <= fmr_pkg::FMR_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // update enable divider; the loop only moves on these pulses
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tick_cnt_ff <= 20'h00000;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 20'(UPDATE_CYCLES - 1)) begin
      tick_cnt_ff <= 20'h00000;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 20'h00001;
      tick_ff <= 1'b0;
    end
  end

  // sample the count from the measuring logic on the same clock
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tach_ff <= 16'hffff;
    end else begin
      tach_ff <= TACH_COUNT;
    end
  end

  // rise and fall limited to the step value unless the target is off or the floor lifts the drive
  always_comb begin
    head_room = `FMR_DRIVE_FULL - rif.drive;
    up_step = (rif.step < head_room) ? rif.step : head_room;
    down_step = (rif.step < rif.drive) ? rif.step : rif.drive;
    // a larger count is a slower fan, so it needs more drive
    if (rif.target == `FMR_TARGET_OFF) begin
      raw_drive = `FMR_DRIVE_OFF;
    end else if (tach_ff > rif.target) begin
      raw_drive = rif.drive + up_step;
    end else if (tach_ff < rif.target) begin
      raw_drive = rif.drive - down_step;
    end else begin
      raw_drive = rif.drive;
    end
    // floor applies whenever the fan is commanded on
    if (rif.target != `FMR_TARGET_OFF && raw_drive < rif.min_drive) begin
      nxt_drive = rif.min_drive;
    end else begin
      nxt_drive = raw_drive;
    end
  end

  // loop output, one strobe per update while the loop is enabled
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      loop_drive_ff <= `FMR_RST_FAN_DRIVE;
      loop_upd_ff <= 1'b0;
    end else begin
      loop_upd_ff <= tick_ff && rif.cfg1[`FMR_CFG1_EN_BIT];
      if (tick_ff) begin
        loop_drive_ff <= nxt_drive;
      end
    end
  end

  // target plus tolerance, kept one bit wider to avoid wrap
  assign fail_limit = {1'b0, rif.target} + {1'b0, rif.fail_band};

  // fan health flags
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      stall_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      // high count byte above threshold means stalled
      stall_ff <= (rif.drive != `FMR_DRIVE_OFF) && (tach_ff[15:8] > rif.valid_tach);
      // full drive yet still slower than target plus band
      fail_ff <= (rif.drive == `FMR_DRIVE_FULL) && ({1'b0, tach_ff} > fail_limit);
    end
  end

  // carrier connections
  assign rif.addr = ptr_ff;
  assign rif.wdata = wdata_ff;
  assign rif.wr_stb = wr_ff;
  assign rif.tach = tach_ff;
  assign rif.strap = strap_s2_ff;
  assign rif.loop_drive = loop_drive_ff;
  assign rif.loop_upd = loop_upd_ff;

  // register bank
  fmr_regbank u_bank (
    .clk(CLK_SYS),
    .reset(RESET),
    .rb(rif.bank)
  );

  // pins: open drain, only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_ff;
  assign FAN_DRIVE = rif.drive;
  assign FAN_STALL = stall_ff;
  assign FAN_DRIVE_FAIL = fail_ff;
endmodule // fmr_top

/* verification/fmr_host.sv */
// serial host model that reaches the fan monitor registers
`timescale 1ns/1ns
module fmr_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  logic [7:0] junk;
  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // step n clocks, land just after the edge
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // open drain: pull low for a zero, sample in the high phase
  task automatic bit_x(input logic b, output logic r);
    hw(2);
    pull = !b;
    hw(8);
    scl = 1'b1;
    hw(5);
    r = sda;
    hw(5);
    scl = 1'b0;
  endtask
  // start (s low) or stop (s high): data moves while clock high
  task automatic edge_x(input logic s);
    hw(2);
    pull = s;
    hw(8);
    scl = 1'b1;
    hw(10);
    pull = !s;
    hw(10);
    if (!s) scl = 1'b0;
  endtask
  // eight bits msb first, ninth released for the answer
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], a);
      q[i] = a;
    end
    bit_x(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    edge_x(1'b0);
    byte_x({7'h2c, 1'b0}, junk);
    byte_x(a, junk);
    byte_x(d, junk);
    edge_x(1'b1);
  endtask
  // read ends with a released ninth bit, so the host declines more
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    edge_x(1'b0);
    byte_x({7'h2c, 1'b0}, junk);
    byte_x(a, junk);
    edge_x(1'b0);
    byte_x({7'h2c, 1'b1}, junk);
    byte_x(8'hff, q);
    edge_x(1'b1);
  endtask
endmodule // fmr_host

/* verification/fmr_chk.sv */
// pin-level assertions of the fan monitor register block
`timescale 1ns/1ns
module fmr_chk (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [15:0] TACH_COUNT,
  input wire logic [7:0] STRAP_PINS,
  input wire logic [7:0] FAN_DRIVE,
  input wire logic FAN_STALL,
  input wire logic FAN_DRIVE_FAIL
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  rst_quiet_a:
    assert property (disable iff (1'b0) RESET |=> FAN_DRIVE == 8'h00 && !FAN_STALL && !SDA_OE)
      else $error("not cleared by reset");
  boot_drive_a:
    assert property ($fell(RESET) |-> (FAN_DRIVE == 8'h00) [*8]) else $error("drive moved");
  oe_low_a:
    assert property ($rose(SDA_OE) |-> !SCL_IN) else $error("data set in clock high");
  oe_held_a:
    assert property ($rose(SDA_OE) |=> SDA_OE [*8]) else $error("data bit short");
  oe_free_a:
    assert property (SDA_OE |-> ##[1:400] !SDA_OE) else $error("data held too long");
  stall_idle_a:
    assert property ((FAN_DRIVE == 8'h00) [*3] |-> !FAN_STALL) else $error("stall when off");
  stall_hi_a:
    assert property ((FAN_DRIVE != 8'h00 && TACH_COUNT[15:8] == 8'hff) [*3] |-> FAN_STALL)
      else $error("stall missed");
  fail_full_a:
    assert property ((FAN_DRIVE != 8'hff) [*3] |-> !FAN_DRIVE_FAIL) else $error("fail early");
  cover property ($rose(FAN_STALL));
  cover property ($rose(FAN_DRIVE_FAIL));
  cover property ($rose(SDA_OE));
endmodule // fmr_chk
bind fmr_top fmr_chk chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .TACH_COUNT(TACH_COUNT), .STRAP_PINS(STRAP_PINS),
  .FAN_DRIVE(FAN_DRIVE), .FAN_STALL(FAN_STALL), .FAN_DRIVE_FAIL(FAN_DRIVE_FAIL));

/* verification/fan_monitor_register_map_test.sv */
// self-checking bench of the fan monitor register map
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %s", $time, m); end end
module fan_monitor_register_map_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] tach = 16'hffff;
  logic scl, pull, sda_oe, sda_out, stall, fail;
  logic [7:0] drive, q;
  logic [7:0] hist [$];
  int bad_count = 0;
  int num_checks = 0;
  // address beside expected boot value; 50h is unmapped
  logic [15:0] rows [22] = '{16'h3255, 16'h3455, 16'h4000, 16'h422b, 16'h4328, 16'h452a,
    16'h4600, 16'h4710, 16'h4866, 16'h49f5, 16'h4a00, 16'h4b00, 16'h4cf8, 16'h4dff, 16'h4eff,
    16'h4fff, 16'hef00, 16'hfc5a, 16'hfd7a, 16'hfe4e, 16'hff03, 16'h5000};
  // pulled-up data wire
  wire sda = !((sda_oe && !sda_out) || pull);
  always #20 clk_sys = !clk_sys;
  fmr_top #(.UPDATE_CYCLES(20)) dut (.CLK_SYS(clk_sys), .RESET(reset), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TACH_COUNT(tach), .STRAP_PINS(8'h5a),
    .FAN_DRIVE(drive), .FAN_STALL(stall), .FAN_DRIVE_FAIL(fail));
  fmr_host host (.clk(clk_sys), .sda(sda), .scl(scl), .pull(pull));
  // log each new drive value, sampled after the edge settles
  always @(posedge clk_sys) begin
    #1;
    if (!reset && (hist.size() == 0 || hist[$] !== drive)) hist.push_back(drive);
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    `CHK(q, e, "register read")
  endtask
  // expected drive history: boot, direct write, floor, steps of 10h, then full
  function automatic logic [7:0] exp_step(input int i);
    return (i == 0) ? 8'h00 : (i == 1) ? 8'h33 : (i > 11) ? 8'hff : 8'(8'h46 + 8'h10 * i);
  endfunction
  // bounded wait until drive reaches v
  task automatic wait_drv(input logic [7:0] v);
    int n;
    for (n = 0; n < 3000 && drive !== v; n++) #40;
    if (n == 3000) begin
      `CHK(1'b0, 1'b1, "timed out")
      complete_run();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    #160;
    foreach (rows[i]) rchk(rows[i][15:8], rows[i][7:0]);
    $display("boot done");
    host.wr(8'h40, 8'h33);
    `CHK(drive, 8'h33, "direct drive")
    host.wr(8'h50, 8'h3c);
    host.wr(8'h4e, 8'h00);
    host.wr(8'hfd, 8'h00);
    rchk(8'h50, 8'h00);
    rchk(8'h4e, 8'hff);
    rchk(8'hfd, 8'h7a);
    `CHK(drive, 8'h33, "drive kept")
    $display("write done");
    host.wr(8'hef, 8'h01);
    host.wr(8'h48, 8'h20);
    host.wr(8'hef, 8'h00);
    rchk(8'h48, 8'h66);
    rchk(8'hef, 8'h01);
    $display("lock done");
    // loop runs under lock: config one and target stay writable
    host.wr(8'h4c, 8'h00);
    host.wr(8'h4d, 8'h00);
    rchk(8'h4d, 8'h00);
    host.wr(8'h42, 8'hab);
    wait_drv(8'hff);
    #160;
    `CHK(fail, 1'b1, "fail flag")
    `CHK(stall, 1'b1, "stall flag")
    rchk(8'h40, 8'hff);
    // floor lifts 33h to 66h, then steps of 10h up to full
    `CHK(hist.size(), 13, "drive steps")
    foreach (hist[i]) `CHK(hist[i], exp_step(i), "drive step")
    tach = 16'h1234;
    #200;
    `CHK(stall, 1'b0, "stall clear")
    rchk(8'h4f, 8'h34);
    $display("loop done");
    // second reset in mid-run: defaults return and the lock lets go
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    #160;
    `CHK(drive, 8'h00, "drive after reset")
    rchk(8'hef, 8'h00);
    rchk(8'h4c, 8'hf8);
    $display("reset done");
    complete_run();
  end
endmodule // fan_monitor_register_map_test
